// *** src/esmr_pkg.sv ***
// Package for the emergency-stop monitored-reset block: register map, field layout,
// reset values, timing counts and the reset sequencer state type.
// Assumes a single 40 MHz clock and a 32-bit APB register port.
`default_nettype none

package esmr_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_TERM = 8'h04;
    localparam logic [7:0] OFF_FILT = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

    // Control register fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_DUAL = 1;
    localparam int CTRL_ERR_EN = 2;
    localparam int CTRL_IND_EN = 3;
    localparam int CTRL_TWO_NODE = 4;
    localparam int CTRL_RELAY_SEL = 5;
    localparam int CTRL_W = 6;

    // Terminal select register: three 4-bit terminal numbers, then three polarity bits
    localparam int TERM_NUM_W = 4;
    localparam int TERM_POL_LSB = 12;
    localparam int TERM_W = 15;
    localparam int N_FUNC = 3;
    localparam int FN_CH_A = 0;
    localparam int FN_CH_B = 1;
    localparam int FN_BUTTON = 2;
    localparam int N_TERM = 14;

    // Interrupt status bits
    localparam int EV_STOP_TRIP = 0;
    localparam int EV_ERROR = 1;
    localparam int EV_LINK_LOST = 2;
    localparam int EV_RELAY_ON = 3;
    localparam int N_EV = 4;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h03;
    localparam logic [TERM_W-1:0] TERM_RST = 15'h7842;
    localparam logic [15:0] FILT_RST = 16'h0000;
    localparam logic [N_EV-1:0] IRQ_MASK_RST = 4'h0;

    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam logic [15:0] OFF_FILT_MS = 16'h0002;
    localparam logic [15:0] DISC_MS = 16'h0064;

    typedef enum logic [1:0] {
        MR_ARM,
        MR_LOW,
        MR_HIGH,
        MR_ON
    } esmr_mr_e;

endpackage : esmr_pkg

`default_nettype wire

// *** src/esmr_top.sv ***
// Emergency-stop input qualification, monitored reset and relay drive, with APB registers.
// Assumes field terminals arrive asynchronously and are synchronised here; the radio
// link status and the remote node's stop state arrive as asynchronous levels too.
//
// The address map and the APB interface to the registers are this design's own decisions.
`default_nettype none

// Notes on behaviour
// - The stop output is 1 only while every assigned channel terminal shows its active level.
// - The configurable filter delays only the change into the active state.
// - An opening stop contact drops the stop output once it has stayed open for the fixed 2 ms filter, plus the synchroniser delay.
// - The stop input works in dual-channel mode by default or single-channel, each with its own terminal.
// - An enabled error output flags a channel discrepancy for downstream use.
// - Each input function can be mapped to any general terminal from 1 to 14.
// - With the stop output at 1, the relay energises only after the button goes low, high, low.
// - The relay function drives one of the two dedicated relay terminals 15 or 16.
// - With indication enabled, the button terminal is driven as an indicator as well as read.
// - In two-node mode a pressed stop at either node de-energises the relay.
// - Start-up is blocked while the local stop is pressed, and in two-node mode also while the remote stop is pressed or the radio link is absent.
// - In two-node mode link loss drops the relay like a stop, and a fresh monitored reset is then needed.
module esmr_top #(
    parameter int unsigned MS_CYCLES = esmr_pkg::MS_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [13:0] term_in,
    output logic [13:0] term_out,
    output logic [13:0] term_oe,
    input wire logic link_ok_in,
    input wire logic remote_stop_ok_in,
    output logic [1:0] relay_out,
    output logic error_out,
    output logic irq
);

    // Register map, one aligned 32-bit word each; unused bits read 0 and ignore writes.
    // CTRL (read/write):
    //   run           relay may energise at all
    //   dual          both stop channels must be active; off means channel A alone
    //   err_en        error_out follows the latched channel discrepancy
    //   ind_en        the button terminal also drives the reset lamp
    //   two_node      the remote stop and the radio link join the permissive
    //   relay_sel     0 drives the first relay terminal, 1 the second
    // TERM (read/write):
    //   three 4-bit terminal numbers for channel A, channel B and the button;
    //   1 to 14 selects a general terminal, 0 or 15 leaves the function inactive;
    //   then one polarity bit per function, 1 meaning a high terminal is active
    // FILT (read/write): activation_filter_time in ms, 0 leaving only the sync delay
    // STATUS (read only, writes dropped without error):
    //   stop_on       filtered stop function output
    //   err           latched discrepancy
    //   link_ok       settled radio link level
    //   remote_ok     settled remote stop level
    //   button        button function active
    //   relay         either relay energised
    //   mr            monitored reset state, two bits
    // IRQ_STAT (write one to clear; a same-cycle event wins over the clear):
    //   stop trip, error raised, link lost in two-node mode, relay energised
    // IRQ_MASK (read/write): same layout; irq is high while any unmasked bit is set
    // Unmapped offsets answer with pslverr and read 0; a write there is dropped.
    // Every access has zero wait states: pready follows the setup cycle.

    typedef struct packed {
        // Synchroniser stages and settled levels
        logic [13:0] t1;
        logic [13:0] t2;
        logic [13:0] t3;
        logic [13:0] term;
        logic [1:0] x1;
        logic [1:0] x2;
        logic [1:0] x3;
        logic [1:0] ext;
        // Millisecond prescalers and counters of the stop filter and discrepancy timer
        logic [15:0] fpre;
        logic [15:0] fms;
        logic [15:0] dpre;
        logic [15:0] dms;
        // Filtered stop function, discrepancy latch and monitored reset
        logic stop_on;
        logic err;
        esmr_pkg::esmr_mr_e mr;
        // Software registers
        logic [esmr_pkg::CTRL_W-1:0] ctrl;
        logic [esmr_pkg::TERM_W-1:0] tsel;
        logic [15:0] filt;
        logic [esmr_pkg::N_EV-1:0] ist;
        logic [esmr_pkg::N_EV-1:0] imask;
        // Registered outputs
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [1:0] relay;
        logic [13:0] tout;
        logic [13:0] toe;
        logic err_out;
        logic irq;
    } esmr_state_s;

    esmr_state_s s_q;
    esmr_state_s s_d;

    // Last prescaler count of one millisecond tick
    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    // Terminal mapping per input function; an unassigned terminal reads inactive
    // Polarity bit 1 makes a high terminal the active level
    logic [esmr_pkg::N_FUNC-1:0] fn_in;
    for (genvar g = 0; g < esmr_pkg::N_FUNC; g++) begin : g_fn
        logic [3:0] num;
        logic [3:0] idx;
        assign num = s_q.tsel[g*esmr_pkg::TERM_NUM_W +: esmr_pkg::TERM_NUM_W];
        assign idx = num - 4'h1;
        assign fn_in[g] = (num >= 4'h1 && num <= 4'hE) ?
            (s_q.term[idx] ~^ s_q.tsel[esmr_pkg::TERM_POL_LSB + g]) : 1'b0;
    end

    // One-hot decode of the button terminal for the lamp drive
    logic [esmr_pkg::N_TERM-1:0] btn_term;
    for (genvar t = 0; t < esmr_pkg::N_TERM; t++) begin : g_btn
        assign btn_term[t] = s_q.tsel[2*esmr_pkg::TERM_NUM_W +: esmr_pkg::TERM_NUM_W] ==
            4'(t + 1);
    end

    // A synchronised level is taken only once the last two stages agree,
    // so a change landing on a clock edge cannot reach the logic half-settled
    logic [esmr_pkg::N_TERM-1:0] term_agree;
    logic [1:0] ext_agree;
    assign term_agree = ~(s_q.t2 ^ s_q.t3);
    assign ext_agree = ~(s_q.x2 ^ s_q.x3);

    localparam int N_EVB = esmr_pkg::N_EV;

    // Decoded controls and settled inputs
    logic dual;
    logic two_node;
    logic link_ok;
    logic remote_ok;
    logic button;
    logic raw_on;
    logic disagree;
    logic perm;
    logic tick;
    logic [15:0] fnext;
    logic [15:0] flimit;
    logic [N_EVB-1:0] ev;
    logic setup;
    logic wr_fire;
    logic [31:0] rd_mux;
    logic rd_bad;
    logic [31:0] status;

    assign dual = s_q.ctrl[esmr_pkg::CTRL_DUAL];
    assign two_node = s_q.ctrl[esmr_pkg::CTRL_TWO_NODE];
    assign link_ok = s_q.ext[0];
    assign remote_ok = s_q.ext[1];
    assign button = fn_in[esmr_pkg::FN_BUTTON];
    // Channels are compared only in dual mode; single mode never latches an error
    assign disagree = dual && (fn_in[esmr_pkg::FN_CH_A] != fn_in[esmr_pkg::FN_CH_B]);
    // All assigned channels must be active, and a latched discrepancy forces off
    assign raw_on = fn_in[esmr_pkg::FN_CH_A] && (!dual || fn_in[esmr_pkg::FN_CH_B]) &&
        !s_q.err;
    // A remote stop or a missing link is treated the same as a local stop
    // Clearing run also drops the relay and demands a fresh reset sequence
    assign perm = s_q.stop_on && s_q.ctrl[esmr_pkg::CTRL_RUN] &&
        (!two_node || (link_ok && remote_ok));
    // One tick per MS_CYCLES clocks; the prescaler restarts with the filter count
    assign tick = (s_q.fpre == MS_LAST);
    assign fnext = s_q.fms + {15'h0000, tick};
    // The configured filter applies only towards the active state
    assign flimit = raw_on ? s_q.filt : esmr_pkg::OFF_FILT_MS;

    // Bus phase decode
    assign setup = psel && !penable;
    assign wr_fire = psel && penable && s_q.pready && pwrite && !s_q.pslverr;

    assign status = {
        24'h000000,
        s_q.mr,
        s_q.relay != 2'b00,
        button,
        remote_ok,
        link_ok,
        s_q.err,
        s_q.stop_on
    };

    // Read data is selected from the setup-cycle address and registered at the setup edge
    always_comb begin
        rd_mux = 32'h00000000;
        rd_bad = 1'b0;
        case (paddr)
            esmr_pkg::OFF_CTRL: rd_mux = {26'h0000000, s_q.ctrl};
            esmr_pkg::OFF_TERM: rd_mux = {17'h00000, s_q.tsel};
            esmr_pkg::OFF_FILT: rd_mux = {16'h0000, s_q.filt};
            esmr_pkg::OFF_STATUS: rd_mux = status;
            esmr_pkg::OFF_IRQ_STAT: rd_mux = {28'h0000000, s_q.ist};
            esmr_pkg::OFF_IRQ_MASK: rd_mux = {28'h0000000, s_q.imask};
            default: rd_bad = 1'b1;
        endcase
    end

    always_comb begin
        s_d = s_q;

        // Three-stage synchronisers; a change is taken once stages two and three agree
        s_d.t1 = term_in;
        s_d.t2 = s_q.t1;
        s_d.t3 = s_q.t2;
        for (int i = 0; i < esmr_pkg::N_TERM; i++) begin
            if (term_agree[i]) begin
                s_d.term[i] = s_q.t3[i];
            end
        end
        s_d.x1 = {remote_stop_ok_in, link_ok_in};
        s_d.x2 = s_q.x1;
        s_d.x3 = s_q.x2;
        for (int i = 0; i < 2; i++) begin
            if (ext_agree[i]) begin
                s_d.ext[i] = s_q.x3[i];
            end
        end

        // Stop filter: counting only while the input differs from the output.
        // Any return of the input clears the count, so bounce restarts the time.
        // A drop therefore takes 2 ms plus the synchroniser depth, whatever FILT holds.
        if (raw_on == s_q.stop_on) begin
            s_d.fpre = 16'h0000;
            s_d.fms = 16'h0000;
        end else if (fnext >= flimit) begin
            s_d.stop_on = raw_on;
            s_d.fpre = 16'h0000;
            s_d.fms = 16'h0000;
        end else begin
            s_d.fpre = tick ? 16'h0000 : s_q.fpre + 16'h0001;
            s_d.fms = fnext;
        end

        // Channel discrepancy: latched until both channels read inactive
        // A lasting discrepancy forces the stop function off until both channels open,
        // so a welded contact cannot hide behind the healthy channel
        if (!disagree) begin
            s_d.dpre = 16'h0000;
            s_d.dms = 16'h0000;
        end else if (s_q.dpre == MS_LAST) begin
            s_d.dpre = 16'h0000;
            s_d.dms = s_q.dms + 16'h0001;
        end else begin
            s_d.dpre = s_q.dpre + 16'h0001;
        end
        if (disagree && s_q.dms >= esmr_pkg::DISC_MS) begin
            s_d.err = 1'b1;
        end else if (!fn_in[esmr_pkg::FN_CH_A] && !fn_in[esmr_pkg::FN_CH_B]) begin
            s_d.err = 1'b0;
        end

        // Monitored reset; losing the permissive always re-arms the sequence
        // The button has only the synchroniser as filter, so a press that bounces
        // can run through the whole sequence; a filtered button would prevent it
        if (!perm) begin
            s_d.mr = esmr_pkg::MR_ARM;
        end else begin
            case (s_q.mr)
                esmr_pkg::MR_ARM: if (!button) s_d.mr = esmr_pkg::MR_LOW;
                esmr_pkg::MR_LOW: if (button) s_d.mr = esmr_pkg::MR_HIGH;
                esmr_pkg::MR_HIGH: if (!button) s_d.mr = esmr_pkg::MR_ON;
                esmr_pkg::MR_ON: s_d.mr = esmr_pkg::MR_ON;
                default: s_d.mr = esmr_pkg::MR_ARM;
            endcase
        end
        // Relay follows the next reset state so it drops on the edge that loses the permissive
        s_d.relay[0] = (s_d.mr == esmr_pkg::MR_ON) && !s_q.ctrl[esmr_pkg::CTRL_RELAY_SEL];
        s_d.relay[1] = (s_d.mr == esmr_pkg::MR_ON) && s_q.ctrl[esmr_pkg::CTRL_RELAY_SEL];

        // Lamp on the button terminal lights while a reset is awaited
        // It stays dark once the relay is on and while the permissive is missing
        s_d.tout = 14'h0000;
        s_d.toe = 14'h0000;
        for (int i = 0; i < esmr_pkg::N_TERM; i++) begin
            if (s_q.ctrl[esmr_pkg::CTRL_IND_EN] && btn_term[i]) begin
                s_d.toe[i] = 1'b1;
                s_d.tout[i] = perm && (s_q.mr != esmr_pkg::MR_ON);
            end
        end
        // Gated here so the latched error stays visible in STATUS when the output is off
        s_d.err_out = s_d.err && s_q.ctrl[esmr_pkg::CTRL_ERR_EN];

        // APB: answer in the cycle after setup, with data captured at setup
        // A write lands only at the access edge and never after a refused address
        s_d.pready = setup;
        s_d.pslverr = setup && rd_bad;
        s_d.prdata = setup && !pwrite ? rd_mux : 32'h00000000;
        if (wr_fire) begin
            case (paddr)
                esmr_pkg::OFF_CTRL: s_d.ctrl = pwdata[esmr_pkg::CTRL_W-1:0];
                esmr_pkg::OFF_TERM: s_d.tsel = pwdata[esmr_pkg::TERM_W-1:0];
                esmr_pkg::OFF_FILT: s_d.filt = pwdata[15:0];
                esmr_pkg::OFF_IRQ_STAT: s_d.ist = s_q.ist & ~pwdata[N_EVB-1:0];
                esmr_pkg::OFF_IRQ_MASK: s_d.imask = pwdata[N_EVB-1:0];
                default: s_d.ctrl = s_q.ctrl;
            endcase
        end

        // Events set after the clear so a same-cycle event is kept
        ev[esmr_pkg::EV_STOP_TRIP] = s_q.stop_on && !s_d.stop_on;
        ev[esmr_pkg::EV_ERROR] = !s_q.err && s_d.err;
        ev[esmr_pkg::EV_LINK_LOST] = two_node && link_ok && !s_d.ext[0];
        ev[esmr_pkg::EV_RELAY_ON] = (s_q.relay == 2'b00) && (s_d.relay != 2'b00);
        s_d.ist = s_d.ist | ev;
        s_d.irq = |(s_d.ist & s_d.imask);
    end

    // Software registers reset to their defaults, all other state to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{
                mr: esmr_pkg::MR_ARM,
                ctrl: esmr_pkg::CTRL_RST,
                tsel: esmr_pkg::TERM_RST,
                filt: esmr_pkg::FILT_RST,
                imask: esmr_pkg::IRQ_MASK_RST,
                default: '0
            };
        end else begin
            s_q <= s_d;
        end
    end

    // Every output is a register bit, so no pin sees decode glitches
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign term_out = s_q.tout;
    assign term_oe = s_q.toe;
    assign relay_out = s_q.relay;
    assign error_out = s_q.err_out;
    assign irq = s_q.irq;

endmodule : esmr_top

`default_nettype wire

// *** tb/esmr_monitor.sv ***
// Checker for the stop monitor block: bus timing, relay and terminal drive relations.
// Assumes it is bound to esmr_top, sees only its ports, and stop channel A stays on terminal 2.
`default_nettype none

module esmr_monitor #(
    parameter int unsigned MS_CYCLES = 40000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic [13:0] term_in,
    input wire logic [13:0] term_oe,
    input wire logic [1:0] relay_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned off_cnt_q;

    // Counts how long channel A has stayed open; saturates so long runs cannot wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_cnt_q <= 0;
        end else if (term_in[1]) begin
            off_cnt_q <= 0;
        end else if (off_cnt_q < 32'd1000000) begin
            off_cnt_q <= off_cnt_q + 1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_bad_setup;
        s_setup ##0 (paddr > 8'h14);
    endsequence

    property p_ready; s_setup |=> pready; endproperty
    property p_ready_one; pready |=> !pready; endproperty
    property p_err_ready; pslverr |-> pready; endproperty
    property p_unmapped; s_bad_setup |=> pslverr && prdata == 32'h0; endproperty
    property p_rd_idle; !pready |-> prdata == 32'h0; endproperty
    property p_relay_one; $onehot0(relay_out); endproperty
    property p_oe_one; $onehot0(term_oe); endproperty
    property p_stop_off; off_cnt_q > 2 * MS_CYCLES + 8 |-> relay_out == 2'b00; endproperty

    a_ready: assert property (p_ready) else $error("no ready after setup");
    a_ready_one: assert property (p_ready_one) else $error("ready held two cycles");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside access");
    a_relay_one: assert property (p_relay_one) else $error("both relays driven");
    a_oe_one: assert property (p_oe_one) else $error("extra terminal driven");
    a_stop_off: assert property (p_stop_off) else $error("relay on with stop open");
endmodule : esmr_monitor

bind esmr_top esmr_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .term_in(term_in), .term_oe(term_oe), .relay_out(relay_out));

`default_nettype wire

// *** tb/esmr_field_model.sv ***
// Field side model: two normally closed stop contacts on terminals 2 and 4, button on 8.
// Assumes the bench commands the contacts; unassigned terminals float.
`default_nettype none

module esmr_field_model (
    input wire logic pclk,
    input wire logic stop_a_ok,
    input wire logic stop_b_ok,
    input wire logic btn_pressed,
    output logic [13:0] term_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] noise_q = 14'h1555;

    // Floating terminals must not look like a steady level
    always @(posedge pclk) noise_q <= ~noise_q;

    always_comb begin
        term_in = noise_q;
        term_in[1] = stop_a_ok;
        term_in[3] = stop_b_ok;
        // Lamp current flows through the series resistor, so the contact sets the level
        term_in[7] = btn_pressed;
    end
endmodule : esmr_field_model

`default_nettype wire

// *** tb/test_esmr_top.sv ***
// Self-checking bench for esmr_top with a register model and the field contact model.
// Assumes a 1 ms tick of 20 cycles so every filter time stays short.
`default_nettype none

module test_esmr_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC = 20;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, error_out, irq, a_ok = 1'b0, b_ok = 1'b0, btn = 1'b0;
    logic link_ok_in = 1'b1, remote_stop_ok_in = 1'b1;
    logic [13:0] term_in, term_out, term_oe;
    logic [1:0] relay_out;
    int err_count = 0, total_checks = 0, n;
    int rm[6] = '{32'(esmr_pkg::CTRL_RST), 32'(esmr_pkg::TERM_RST), 32'(esmr_pkg::FILT_RST),
        32'h0C, 0, 32'(esmr_pkg::IRQ_MASK_RST)};

    always #12.5 pclk = ~pclk;

    esmr_top #(.MS_CYCLES(MSC)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .term_in(term_in), .term_out(term_out),
        .term_oe(term_oe), .link_ok_in(link_ok_in), .remote_stop_ok_in(remote_stop_ok_in),
        .relay_out(relay_out), .error_out(error_out), .irq(irq));
    esmr_field_model u_field (.pclk(pclk), .stop_a_ok(a_ok), .stop_b_ok(b_ok),
        .btn_pressed(btn), .term_in(term_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w && a < 8'h18 && a != 8'h0C && a != 8'h10) rm[a / 4] = d;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd & m, exp);
    endtask

    task automatic wait_relay(input bit on, input int lim);
        logic [1:0] exp;
        exp = !on ? 2'b00 : (rm[0] & 32'h20) != 0 ? 2'b10 : 2'b01;
        for (n = 0; n < lim && relay_out !== exp; n++) @(posedge pclk);
        chk(32'(relay_out), 32'(exp));
    endtask

    task automatic reset_seq();
        btn <= 1'b0;
        repeat ($urandom_range(12, 6)) @(posedge pclk);
        btn <= 1'b1;
        repeat ($urandom_range(12, 6)) @(posedge pclk);
        btn <= 1'b0;
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        $display("mismatch at %0t: timeout", $time);
        summarize();
    end

    initial begin
        void'($urandom(60919));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) rdchk(8'(4 * i), 32'hFFFFFFFF, 32'(rm[i]));
        apb(1'b0, 8'h18, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1'b1, 8'h08, $urandom);
        rdchk(8'h08, 32'hFFFFFFFF, 32'(rm[2]) & 32'h0000FFFF);
        apb(1'b1, 8'h00, 32'h07);
        apb(1'b1, 8'h08, 32'h03);
        apb(1'b1, 8'h14, 32'h0F);
        a_ok <= 1'b1;
        b_ok <= 1'b1;
        repeat (2 * MSC) @(posedge pclk);
        rdchk(8'h0C, 32'h1, 32'h0);
        repeat (2 * MSC) @(posedge pclk);
        rdchk(8'h0C, 32'h1, 32'h1);
        wait_relay(1'b0, 1);
        reset_seq();
        wait_relay(1'b1, 20);
        rdchk(8'h10, 32'hF, 32'h8);
        chk(irq, 1'b1);
        apb(1'b1, 8'h10, 32'h8);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        b_ok <= 1'b0;
        repeat (2 * MSC - 4) @(posedge pclk);
        wait_relay(1'b1, 1);
        wait_relay(1'b0, 12);
        rdchk(8'h10, 32'h1, 32'h1);
        for (n = 0; n < 2200 && error_out !== 1'b1; n++) @(posedge pclk);
        chk(error_out, 1'b1);
        a_ok <= 1'b0;
        repeat (10) @(posedge pclk);
        chk(error_out, 1'b0);
        apb(1'b1, 8'h10, 32'hF);
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h00, 32'h31);
        a_ok <= 1'b1;
        repeat (10) @(posedge pclk);
        rdchk(8'h0C, 32'h1, 32'h1);
        link_ok_in <= 1'b0;
        reset_seq();
        wait_relay(1'b0, 10);
        link_ok_in <= 1'b1;
        repeat (8) @(posedge pclk);
        reset_seq();
        wait_relay(1'b1, 20);
        remote_stop_ok_in <= 1'b0;
        wait_relay(1'b0, 10);
        remote_stop_ok_in <= 1'b1;
        repeat (8) @(posedge pclk);
        reset_seq();
        wait_relay(1'b1, 20);
        apb(1'b1, 8'h10, 32'hF);
        link_ok_in <= 1'b0;
        wait_relay(1'b0, 10);
        link_ok_in <= 1'b1;
        repeat (20) @(posedge pclk);
        wait_relay(1'b0, 1);
        rdchk(8'h10, 32'h4, 32'h4);
        apb(1'b1, 8'h00, 32'h39);
        repeat (3) @(posedge pclk);
        chk(32'(term_oe), 32'h80);
        chk(32'(term_out), 32'h80);
        reset_seq();
        wait_relay(1'b1, 20);
        repeat (2) @(posedge pclk);
        chk(32'(term_out), 32'h0);
        a_ok <= 1'b0;
        wait_relay(1'b0, 2 * MSC + 8);
        summarize();
    end
endmodule : test_esmr_top

`default_nettype wire
